// [logic/ales_defs.svh]
// timing counts and field widths for the alarm/led status encoder
// assumes clk_sys at 250 MHz
`ifndef ALES_DEFS_SVH
`define ALES_DEFS_SVH
`define ALES_CLK_MHZ        250
`define ALES_BLINK_MS       250
`define ALES_BLINK_CYC      (`ALES_BLINK_MS * 1000 * `ALES_CLK_MHZ)
`define ALES_PULSE_MS       1
`define ALES_PULSE_CYC      (`ALES_PULSE_MS * 1000 * `ALES_CLK_MHZ)
`define ALES_ADDR_W         4
`define ALES_LEVEL_W        8
`define ALES_CNT_W          26
`endif

// [logic/ales_pkg.sv]
// types shared by the alarm/led status encoder
// assumes ales_defs.svh alongside
`include "ales_defs.svh"
package ales_pkg;
    typedef enum logic [1:0] {
        ALES_MODE_BUS   = 2'b01,
        ALES_MODE_RS485 = 2'b10
    } ales_mode_t;
    typedef logic [`ALES_CNT_W-1:0] ales_cnt_t;
endpackage : ales_pkg

// [logic/ales_addr_dec.sv]
// decodes one address-select voltage level into four address bits
// assumes the level arrives as an unsigned sample synchronous to clk_sys
`timescale 1ns/1ps
`include "ales_defs.svh"
module ales_addr_dec
    import ales_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // level in, address out
    input  wire logic [`ALES_LEVEL_W-1:0]  level,
    output logic      [`ALES_ADDR_W-1:0]   addr
);
    typedef struct packed {
        logic [`ALES_ADDR_W-1:0] addr;
    } ales_dec_state_t;
    ales_dec_state_t st;
    ales_dec_state_t next_st;

    // sixteen equal bands: the top nibble of the level is the band
    always_comb begin
        next_st      = st;
        next_st.addr = level[`ALES_LEVEL_W-1 -: `ALES_ADDR_W];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign addr = st.addr;

    property p_dec;
        @(posedge clk_sys) disable iff (rst)
        ##1 addr == $past(level[`ALES_LEVEL_W-1 -: `ALES_ADDR_W]);
    endproperty
    a_dec: assert property (p_dec) else $error("address band wrong");
endmodule : ales_addr_dec

// [logic/ales_encoder.sv]
// alarm, led and output-enable encoder for the supply front panel
// assumes condition inputs are synchronous, active high levels from the supply controls
`timescale 1ns/1ps
`include "ales_defs.svh"
module ales_encoder
    import ales_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // supply conditions
    input  wire logic                      thermAlarm,
    input  wire logic                      thermShutdown,
    input  wire logic                      fanFail0,
    input  wire logic                      fanFail1,
    input  wire logic                      fuseBlown,
    input  wire logic                      boostFail,
    input  wire logic                      overVoltage,
    input  wire logic                      ovLatchRelease,
    input  wire logic                      inputPresent,
    input  wire logic                      inputInLimits,
    input  wire logic                      overCurrent,
    input  wire logic                      internalFault,
    input  wire logic                      serviceReq,
    input  wire logic                      commLost,
    input  wire logic                      remoteStandby,
    input  wire logic                      statusPending,
    // control pins
    input  wire logic                      onOffShort_n,
    input  wire logic                      interlockMade,
    input  wire logic                      protocolTerminated,
    input  wire logic [`ALES_LEVEL_W-1:0]  unit_address_sel,
    input  wire logic [`ALES_LEVEL_W-1:0]  rack_address_sel,
    // indicators
    output logic                           input_ok_led,
    output logic                           output_ok_led,
    output logic                           serviceLed,
    output logic                           faultLed,
    // open drain alarms: out is level, oe high while pulling low; alert_n and module_present_n have no oe
    output logic                           fault_n,
    output logic                           faultOe,
    output logic                           power_good_n,
    output logic                           powerGoodOe,
    output logic                           overtemp_warning_n,
    output logic                           overtempOe,
    output logic                           alert_n,
    output logic                           module_present_n,
    // control results
    output logic                           mainOutputEn,
    output ales_mode_t                     protoMode,
    output logic [`ALES_ADDR_W-1:0]        unitAddr,
    output logic [`ALES_ADDR_W-1:0]        rackAddr
);
    typedef struct packed {
        ales_cnt_t  blinkCnt;
        logic       blink;
        ales_cnt_t  pulseCnt;
        logic       pulse;
        logic       ovLatched;
        logic       inOk;
        logic       outOk;
        logic       svcLed;
        logic       fltLed;
        logic       fltN;
        logic       pgN;
        logic       otwN;
        logic       fltOe;
        logic       pgOe;
        logic       otwOe;
        logic       alertN;
        logic       outEn;
        ales_mode_t mode;
    } ales_state_t;
    ales_state_t st;
    ales_state_t next_st;

    logic shutdown;
    logic dualFan;
    logic hardFault;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        dualFan   = fanFail0 && fanFail1;
        // a lone fan failure is not in this list: temperature decides
        hardFault = fuseBlown || boostFail || st.ovLatched || dualFan || thermShutdown;
        shutdown  = hardFault;
        next_st   = st;
        // free-running blink and overload pulse timers
        if (st.blinkCnt == ales_cnt_t'(`ALES_BLINK_CYC - 1)) begin
            next_st.blinkCnt = '0;
            next_st.blink    = ~st.blink;
        end else begin
            next_st.blinkCnt = st.blinkCnt + ales_cnt_t'(1);
        end
        if (st.pulseCnt == ales_cnt_t'(`ALES_PULSE_CYC - 1)) begin
            next_st.pulseCnt = '0;
            next_st.pulse    = ~st.pulse;
        end else begin
            next_st.pulseCnt = st.pulseCnt + ales_cnt_t'(1);
        end
        // release wins only when the over-voltage itself is gone
        if (overVoltage) begin
            next_st.ovLatched = 1'b1;
        end else if (ovLatchRelease) begin
            next_st.ovLatched = 1'b0;
        end
        next_st.mode = protocolTerminated ? ALES_MODE_RS485 : ALES_MODE_BUS;
        // defaults: healthy unit
        next_st.inOk   = 1'b1;
        next_st.outOk  = 1'b1;
        next_st.svcLed = 1'b0;
        next_st.fltLed = 1'b0;
        next_st.fltN   = 1'b1;
        next_st.pgN    = 1'b1;
        next_st.otwN   = 1'b1;
        // shutdown first, then warnings
        if (shutdown) begin
            next_st.outOk  = 1'b0;
            next_st.fltLed = 1'b1;
            next_st.fltN   = 1'b0;
            next_st.pgN    = 1'b0;
            if (thermShutdown) begin
                next_st.svcLed = 1'b1;
                next_st.otwN   = 1'b0;
            end
        end else if (!inputPresent) begin
            next_st.inOk  = 1'b0;
            next_st.outOk = 1'b0;
            next_st.pgN   = 1'b0;
        end else if (!inputInLimits) begin
            next_st.inOk  = st.blink;
            next_st.outOk = 1'b0;
            next_st.pgN   = 1'b0;
        end else if (remoteStandby || !mainOutEnable(onOffShort_n, interlockMade)) begin
            next_st.outOk = 1'b0;
            next_st.pgN   = 1'b0;
        end else if (overCurrent) begin
            next_st.outOk = st.blink;
            next_st.pgN   = st.pulse;
        end else if (internalFault) begin
            next_st.fltLed = 1'b1;
            next_st.fltN   = 1'b0;
        end else if (thermAlarm) begin
            next_st.svcLed = 1'b1;
            next_st.otwN   = 1'b0;
        end else if (serviceReq && st.mode == ALES_MODE_BUS) begin
            next_st.svcLed = st.blink;
        end else if (commLost && st.mode == ALES_MODE_RS485) begin
            next_st.fltLed = st.blink;
        end
        next_st.outEn  = !shutdown && !remoteStandby
                       && mainOutEnable(onOffShort_n, interlockMade);
        next_st.alertN = ~statusPending;
        // enables are registered too, so every alarm level and its enable come straight off a flop
        next_st.fltOe  = ~next_st.fltN;
        next_st.pgOe   = ~next_st.pgN;
        next_st.otwOe  = ~next_st.otwN;
    end

    function automatic logic mainOutEnable(input logic ctlN, input logic ilk);
        // ilk gates output so it drops before long pins break
        mainOutEnable = !ctlN && ilk;
    endfunction : mainOutEnable

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st        <= '0;
            st.inOk   <= 1'b0;
            st.fltN   <= 1'b1;
            st.pgN    <= 1'b0;
            st.pgOe   <= 1'b1;
            st.otwN   <= 1'b1;
            st.alertN <= 1'b1;
            st.mode   <= ALES_MODE_BUS;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    ales_addr_dec u_unit (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (unit_address_sel),
        .addr    (unitAddr)
    );
    ales_addr_dec u_rack (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (rack_address_sel),
        .addr    (rackAddr)
    );

    assign input_ok_led       = st.inOk;
    assign output_ok_led      = st.outOk;
    assign serviceLed         = st.svcLed;
    assign faultLed           = st.fltLed;
    assign fault_n            = st.fltN;
    assign faultOe            = st.fltOe;
    assign power_good_n       = st.pgN;
    assign powerGoodOe        = st.pgOe;
    assign overtemp_warning_n = st.otwN;
    assign overtempOe         = st.otwOe;
    assign alert_n            = st.alertN;
    assign module_present_n   = 1'b0;
    assign mainOutputEn       = st.outEn;
    assign protoMode          = st.mode;

    ////////////////////////////////////////////////////////////////////////////
    property p_ok;
        @(posedge clk_sys) disable iff (rst)
        ##1 ($past(!hardFault && inputPresent && inputInLimits && !remoteStandby
            && !overCurrent && !internalFault && !thermAlarm && !serviceReq && !commLost
            && !onOffShort_n && interlockMade))
        |-> (input_ok_led && output_ok_led && !serviceLed && !faultLed && fault_n
            && power_good_n && overtemp_warning_n);
    endproperty
    a_ok: assert property (p_ok) else $error("healthy outputs wrong");

    property p_therm;
        @(posedge clk_sys) disable iff (rst)
        (thermAlarm && !shutdown && inputPresent && inputInLimits && !remoteStandby
            && !overCurrent && !internalFault && !onOffShort_n && interlockMade)
        |=> (serviceLed && !overtemp_warning_n && fault_n && !power_good_n == 1'b0);
    endproperty
    a_therm: assert property (p_therm) else $error("thermal alarm outputs wrong");

    property p_hard;
        @(posedge clk_sys) disable iff (rst)
        (fuseBlown || boostFail || dualFan)
        |=> (!output_ok_led && faultLed && !fault_n && !power_good_n && faultOe);
    endproperty
    a_hard: assert property (p_hard) else $error("shutdown outputs wrong");

    property p_ovhold;
        @(posedge clk_sys) disable iff (rst)
        (overVoltage ##1 (!ovLatchRelease)[*3]) |=> !fault_n && !power_good_n;
    endproperty
    a_ovhold: assert property (p_ovhold) else $error("ov latch dropped");

    property p_fan1;
        @(posedge clk_sys) disable iff (rst)
        (fanFail0 ^ fanFail1) && !fuseBlown && !boostFail && !st.ovLatched
            && !overVoltage && !thermShutdown && interlockMade && !onOffShort_n
            && !remoteStandby |=> mainOutputEn;
    endproperty
    a_fan1: assert property (p_fan1) else $error("single fan shut output");

    property p_fan2;
        @(posedge clk_sys) disable iff (rst)
        dualFan |=> !mainOutputEn && faultLed;
    endproperty
    a_fan2: assert property (p_fan2) else $error("double fan did not shut");

    property p_onoff;
        @(posedge clk_sys) disable iff (rst)
        (onOffShort_n || !interlockMade) |=> !mainOutputEn;
    endproperty
    a_onoff: assert property (p_onoff) else $error("output enabled without control");

    property p_mode;
        @(posedge clk_sys) disable iff (rst)
        ##1 (protoMode == ($past(protocolTerminated) ? ALES_MODE_RS485 : ALES_MODE_BUS));
    endproperty
    a_mode: assert property (p_mode) else $error("protocol mode wrong");

    property p_alert;
        @(posedge clk_sys) disable iff (rst)
        statusPending[*2] |-> ##1 !alert_n;
    endproperty
    a_alert: assert property (p_alert) else $error("alert not asserted");

    property p_prio;
        @(posedge clk_sys) disable iff (rst)
        (shutdown && thermAlarm && !thermShutdown) |=> overtemp_warning_n && !fault_n;
    endproperty
    a_prio: assert property (p_prio) else $error("warning beat shutdown");

    property p_limits;
        @(posedge clk_sys) disable iff (rst)
        (inputPresent && !inputInLimits && !shutdown)
        |=> (!output_ok_led && !power_good_n && fault_n && overtemp_warning_n);
    endproperty
    a_limits: assert property (p_limits) else $error("out of limits outputs wrong");

    property p_standby;
        @(posedge clk_sys) disable iff (rst)
        (remoteStandby && inputPresent && inputInLimits && !shutdown)
        |=> (input_ok_led && !output_ok_led && !power_good_n && fault_n && !mainOutputEn);
    endproperty
    a_standby: assert property (p_standby) else $error("standby outputs wrong");

    property p_odpair;
        @(posedge clk_sys) disable iff (rst)
        (faultOe == !fault_n) && (powerGoodOe == !power_good_n)
            && (overtempOe == !overtemp_warning_n);
    endproperty
    a_odpair: assert property (p_odpair) else $error("alarm enable and level disagree");
endmodule : ales_encoder

// [dv/ales_shelf_model.sv]
// shelf controller side: pull-ups on the three open-drain alarms, lines sampled by the bench
// assumes the supply sinks a line only while its enable is high
`timescale 1ns/1ps
module ales_shelf_model
    import ales_pkg::*;
(
    // alarm pin enables from the supply
    input  wire logic faultOe,
    input  wire logic powerGoodOe,
    input  wire logic overtempOe,
    // alarm pin levels from the supply
    input  wire logic faultLevel,
    input  wire logic pgLevel,
    input  wire logic otwLevel,
    // resolved line levels
    output logic      faultLine,
    output logic      pgLine,
    output logic      otwLine
);
    // the pad shows its driven level while enabled, the pull-up otherwise
    assign faultLine = faultOe ? faultLevel : 1'b1;
    assign pgLine    = powerGoodOe ? pgLevel : 1'b1;
    assign otwLine   = overtempOe ? otwLevel : 1'b1;
endmodule : ales_shelf_model

// [dv/ales_encoder_tb.sv]
// self-checking bench for the alarm/led status encoder
// assumes the shelf model resolves the alarm lines; inputs change on falling edges
`timescale 1ns/1ps
module ales_encoder_tb;
    import ales_pkg::*;
    typedef struct packed {
        logic thermAlarm, thermShutdown, fanFail0, fanFail1, fuseBlown, boostFail;
        logic overVoltage, ovLatchRelease, inputPresent, inputInLimits, overCurrent;
        logic internalFault, serviceReq, commLost, remoteStandby, statusPending;
    } ales_tb_cond_t;
    logic clk_sys, rst, onOffShort_n, interlockMade, protocolTerminated;
    logic [7:0] unitSel, rackSel;
    ales_tb_cond_t c;
    logic iOk, oOk, svc, flt, fN, fOe, pgN, pgOe, otN, otOe, alN, mpN, en;
    logic fLine, pLine, oLine;
    ales_mode_t mode;
    logic [3:0] uAddr, rAddr;
    logic [8:0] obs;
    int mismatches, n_compared;
    localparam ales_tb_cond_t IDLE = 16'h00c0;
    assign obs = {iOk, oOk, svc, flt, fLine, pLine, oLine, mpN, en};
    ales_encoder u_dut (.clk_sys(clk_sys), .rst(rst), .thermAlarm(c.thermAlarm),
        .thermShutdown(c.thermShutdown), .fanFail0(c.fanFail0), .fanFail1(c.fanFail1),
        .fuseBlown(c.fuseBlown), .boostFail(c.boostFail), .overVoltage(c.overVoltage),
        .ovLatchRelease(c.ovLatchRelease), .inputPresent(c.inputPresent),
        .inputInLimits(c.inputInLimits), .overCurrent(c.overCurrent),
        .internalFault(c.internalFault), .serviceReq(c.serviceReq), .commLost(c.commLost),
        .remoteStandby(c.remoteStandby), .statusPending(c.statusPending),
        .onOffShort_n(onOffShort_n), .interlockMade(interlockMade),
        .protocolTerminated(protocolTerminated), .unit_address_sel(unitSel),
        .rack_address_sel(rackSel), .input_ok_led(iOk), .output_ok_led(oOk),
        .serviceLed(svc), .faultLed(flt), .fault_n(fN), .faultOe(fOe),
        .power_good_n(pgN), .powerGoodOe(pgOe), .overtemp_warning_n(otN),
        .overtempOe(otOe), .alert_n(alN), .module_present_n(mpN), .mainOutputEn(en),
        .protoMode(mode), .unitAddr(uAddr), .rackAddr(rAddr));
    ales_shelf_model u_shelf (.faultOe(fOe), .powerGoodOe(pgOe), .overtempOe(otOe),
        .faultLevel(fN), .pgLevel(pgN), .otwLevel(otN),
        .faultLine(fLine), .pgLine(pLine), .otwLine(oLine));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic end_of_test;
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic check_status(input logic [8:0] got, input logic [8:0] exp,
                                input logic [8:0] mask);
        n_compared++;
        if (((got ^ exp) & mask) !== 9'h000) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_status
    task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    // two edges: one to register, one spare; results read on the falling edge
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_steady;
        c = IDLE; settle; check_status(obs, 9'h19d, 9'h1ff);
        c.thermAlarm = 1'b1; settle; check_status(obs, 9'h1d9, 9'h1ff);
        c.thermShutdown = 1'b1; settle; check_status(obs, 9'h160, 9'h1ff);
        c = IDLE; c.internalFault = 1'b1; c.thermAlarm = 1'b1;
        settle; check_status(obs, 9'h1ad, 9'h1ff);
        c = IDLE; c.fuseBlown = 1'b1; settle; check_status(obs, 9'h124, 9'h1ff);
        c = IDLE; c.boostFail = 1'b1; settle; check_status(obs, 9'h124, 9'h1ff);
    endtask : t_steady
    task automatic t_fans;
        c = IDLE; c.fanFail0 = 1'b1; settle; check_status(obs, 9'h001, 9'h001);
        c = IDLE; c.fanFail1 = 1'b1; settle; check_status(obs, 9'h001, 9'h001);
        c.fanFail0 = 1'b1; settle; check_status(obs, 9'h124, 9'h1ff);
    endtask : t_fans
    task automatic t_ov_latch;
        c = IDLE; c.overVoltage = 1'b1;
        @(negedge clk_sys);
        c.overVoltage = 1'b0;
        repeat (8) @(negedge clk_sys);
        check_status(obs, 9'h124, 9'h1ff);
        c.ovLatchRelease = 1'b1; settle; c.ovLatchRelease = 1'b0;
        settle; check_status(obs, 9'h19d, 9'h1ff);
    endtask : t_ov_latch
    // blink and pulse timers start in their off phase and one half period outlasts
    // this whole run, so blinking leds and the overload pulse read low throughout
    task automatic t_limits;
        c = IDLE; c.inputInLimits = 1'b0; settle; check_status(obs, 9'h014, 9'h1fe);
        c = IDLE; c.overCurrent = 1'b1; settle; check_status(obs, 9'h115, 9'h1ff);
        c = IDLE; c.remoteStandby = 1'b1; settle; check_status(obs, 9'h114, 9'h1ff);
        c = IDLE; onOffShort_n = 1'b1; settle; check_status(obs, 9'h114, 9'h1ff);
        onOffShort_n = 1'b0; interlockMade = 1'b0;
        settle; check_status(obs, 9'h114, 9'h1ff);
        c.fuseBlown = 1'b1; settle; check_status(obs, 9'h124, 9'h1ff);
        interlockMade = 1'b1;
    endtask : t_limits
    task automatic t_modes;
        c = IDLE; c.serviceReq = 1'b1; protocolTerminated = 1'b0;
        settle; check_status(obs, 9'h19d, 9'h1ff);
        check_val({2'b00, mode}, 4'h1);
        c.serviceReq = 1'b0; c.commLost = 1'b1; settle; check_status(obs, 9'h19d, 9'h1ff);
        protocolTerminated = 1'b1; settle; check_status(obs, 9'h19d, 9'h1ff);
        check_val({2'b00, mode}, 4'h2);
        c.commLost = 1'b0; c.serviceReq = 1'b1; settle; check_status(obs, 9'h19d, 9'h1ff);
        protocolTerminated = 1'b0;
    endtask : t_modes
    task automatic t_addr_alert;
        for (int i = 0; i < 16; i++) begin
            unitSel = {i[3:0], 4'h5};
            rackSel = {4'(15 - i), 4'ha};
            settle;
            check_val(uAddr, i[3:0]);
            check_val(rAddr, 4'(15 - i));
        end
        c = IDLE; c.statusPending = 1'b1; settle; check_val({3'b000, alN}, 4'h0);
        c.statusPending = 1'b0; settle; check_val({3'b000, alN}, 4'h1);
    endtask : t_addr_alert
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(4 * 20000);
        mismatches++;
        end_of_test;
    end
    initial begin
        mismatches = 0;
        n_compared = 0;
        rst = 1'b1;
        c = IDLE;
        onOffShort_n = 1'b0;
        interlockMade = 1'b1;
        protocolTerminated = 1'b0;
        unitSel = 8'h00;
        rackSel = 8'h00;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        t_steady;
        t_fans;
        t_ov_latch;
        t_limits;
        t_modes;
        t_addr_alert;
        end_of_test;
    end
endmodule : ales_encoder_tb
